// [common/csi_pkg.sv]
// shared constants and types for the cubic spline point interpolator
package csi_pkg;
  // datapath widths
  localparam int NAX       = 8;
  localparam int AX_W      = 3;
  localparam int POS_W     = 24;
  localparam int MULT_W    = 16;
  localparam int MULT_FRAC = 14;
  localparam int T_W       = 16;
  localparam int ACC_W     = 48;
  localparam int TBL_DEPTH = 4096;
  localparam int IDX_W     = 12;
  localparam int CNT_W     = 13;
  localparam int REP_W     = 15;
  localparam int RATE_W    = 9;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_CNT_W = 6;

  // timing: code units per ms, step time, clock rate
  localparam int CLK_MHZ     = 20;
  localparam int STEP_US     = 200;
  localparam int RATE_PER_MS = 5;
  localparam int STEP_CYC    = STEP_US * CLK_MHZ;
  localparam int TICK_W      = 12;
  // one code unit is 1000/5 us, i.e. exactly one interpolation step
  localparam int STEPS_PER_CODE = 1000 / (RATE_PER_MS * STEP_US);

  localparam logic [RATE_W-1:0] RATE_MIN = 9'h005;
  localparam logic [RATE_W-1:0] RATE_MAX = 9'h1ff;
  localparam logic [RATE_W-1:0] RATE_RST = 9'h005;

  // register word addresses
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_RATE  = 8'h04;
  localparam logic [7:0] A_STAGE = 8'h08;
  localparam logic [7:0] A_SHIFT = 8'h0c;
  localparam logic [7:0] A_SPAN  = 8'h10;
  localparam logic [7:0] A_GO    = 8'h14;
  localparam logic [7:0] A_TADDR = 8'h18;
  localparam logic [7:0] A_TDATA = 8'h1c;

  // field positions
  localparam int CTRL_STOP  = 0;
  localparam int CTRL_CLR   = 1;
  localparam int ST_BUSY    = 0;
  localparam int ST_FULL    = 1;
  localparam int ST_OVF     = 2;
  localparam int ST_BADRATE = 3;
  localparam int ST_CNT_LSB = 8;
  localparam int HI_LSB     = 16;

  typedef enum logic [1:0] {
    CSI_CMD_RATE  = 2'h0,
    CSI_CMD_SCALE = 2'h1,
    CSI_CMD_START = 2'h2
  } csi_cmd_e;

  typedef struct packed {
    logic [4:0]        pad;
    logic [AX_W-1:0]   axis;
    logic [MULT_W-1:0] mult;
    logic [POS_W-1:0]  shift;
  } csi_scale_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [IDX_W-1:0] idx;
    logic [REP_W-1:0] rep;
    logic [NAX-1:0]   axes;
  } csi_start_s;

  typedef struct packed {
    csi_cmd_e    op;
    logic [47:0] arg;
  } csi_cmd_s;

  localparam int CMD_W = $bits(csi_cmd_s);

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_WAIT  = 5'b00010,
    S_FETCH = 5'b00100,
    S_DIV   = 5'b01000,
    S_EVAL  = 5'b10000
  } csi_ph_e;

  typedef struct packed {
    csi_ph_e                      ph;
    logic [RATE_W-1:0]            rate;
    logic [NAX-1:0][MULT_W-1:0]   mult;
    logic [NAX-1:0][POS_W-1:0]    shift;
    logic [AX_W-1:0]              stg_axis;
    logic [MULT_W-1:0]            stg_mult;
    logic [CNT_W-1:0]             span_cnt;
    logic [IDX_W-1:0]             span_idx;
    logic [IDX_W-1:0]             taddr;
    csi_start_s                   run;
    logic                         busy;
    logic [CNT_W-1:0]             seg;
    logic [RATE_W-1:0]            k;
    logic [REP_W-1:0]             pass;
    logic [2:0]                   j;
    logic [3:0][POS_W-1:0]        p;
    logic [T_W-1:0]               t;
    logic                         div_go;
    logic [TICK_W-1:0]            tick;
    logic [NAX-1:0][POS_W-1:0]    sp;
    logic                         sp_valid;
    logic                         ovf;
    logic                         badrate;
    logic [31:0]                  rdata;
  } csi_core_s;
endpackage : csi_pkg

// [design/csi_fifo.sv]
// command queue fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module csi_fifo #(
  parameter int W     = 50,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  // fill level
  output logic [AW:0]       level
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_s;

  fifo_s          st_r;
  fifo_s          st_nxt;
  logic [W-1:0]   mem [DEPTH];
  logic           push;
  logic           pop;

  assign in_ready  = st_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_r.cnt != '0;
  assign out_data  = mem[st_r.rp];
  assign level     = st_r.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) st_nxt.wp = st_r.wp + 1'b1;
    if (pop) st_nxt.rp = st_r.rp + 1'b1;
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (rst) st_r <= '0;
    else st_r <= st_nxt;
    if (push) mem[st_r.wp] <= in_data;
  end
endmodule : csi_fifo
`default_nettype wire

// [design/csi_div.sv]
// sequential restoring divider giving the fraction num/den, num < den
`timescale 1ns/1ps
`default_nettype none
module csi_div #(
  parameter int W  = 16,
  parameter int DW = 9
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // request
  input  wire logic          go,
  input  wire logic [DW-1:0] num,
  input  wire logic [DW-1:0] den,
  // answer
  output logic [W-1:0]       quo,
  output logic               done
);
  typedef struct packed {
    logic [DW:0]    rem;
    logic [W-1:0]   q;
    logic [5:0]     n;
    logic           run;
    logic           done;
  } div_s;

  div_s        st_r;
  div_s        st_nxt;
  logic [DW:0] sh;

  assign quo  = st_r.q;
  assign done = st_r.done;
  assign sh   = {st_r.rem[DW-1:0], 1'b0};

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (go) begin
      st_nxt.rem = {1'b0, num};
      st_nxt.n = 6'(W);
      st_nxt.run = 1'b1;
    end else if (st_r.run) begin
      // one quotient bit per cycle keeps the datapath narrow
      if (sh >= {1'b0, den}) begin
        st_nxt.rem = sh - {1'b0, den};
        st_nxt.q = {st_r.q[W-2:0], 1'b1};
      end else begin
        st_nxt.rem = sh;
        st_nxt.q = {st_r.q[W-2:0], 1'b0};
      end
      st_nxt.n = st_r.n - 1'b1;
      if (st_r.n == 6'h01) begin
        st_nxt.run = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) st_r <= '0;
    else st_r <= st_nxt;
  end
endmodule : csi_div
`default_nettype wire

// [design/csi_core.sv]
// cubic spline point interpolator: table, command queue, step engine
`timescale 1ns/1ps
`default_nettype none
module csi_core #(
  parameter int FIFO_DEPTH = csi_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                                         clock,
  input  wire logic                                         rst,
  // register port
  input  wire logic [7:0]                                   addr,
  input  wire logic [31:0]                                  wdata,
  input  wire logic                                         wr,
  input  wire logic                                         rd,
  output logic [31:0]                                       rdata,
  // setpoint stream
  output logic [csi_pkg::NAX-1:0][csi_pkg::POS_W-1:0]       sp,
  output logic                                              sp_valid,
  output logic [csi_pkg::NAX-1:0]                           sp_axes,
  output logic                                              busy
);
  localparam int ACC_W = csi_pkg::ACC_W;
  localparam int POS_W = csi_pkg::POS_W;

  csi_pkg::csi_core_s                     st_r;
  csi_pkg::csi_core_s                     st_nxt;
  logic [POS_W-1:0]                       tbl [csi_pkg::TBL_DEPTH];
  logic [POS_W-1:0]                       tbl_q;
  logic [csi_pkg::IDX_W-1:0]              rd_addr;
  csi_pkg::csi_cmd_s                      q_in;
  csi_pkg::csi_cmd_s                      q_out;
  logic                                   q_in_valid;
  logic                                   q_in_ready;
  logic                                   q_out_valid;
  logic                                   q_out_ready;
  logic [csi_pkg::FIFO_CNT_W-1:0]         q_level;
  logic [csi_pkg::T_W-1:0]                div_q;
  logic                                   div_done;
  logic signed [ACC_W-1:0]                p0;
  logic signed [ACC_W-1:0]                p1;
  logic signed [ACC_W-1:0]                p2;
  logic signed [ACC_W-1:0]                p3;
  logic signed [ACC_W-1:0]                c_a;
  logic signed [ACC_W-1:0]                c_b;
  logic signed [ACC_W-1:0]                c_c;
  logic signed [ACC_W-1:0]                h1;
  logic signed [ACC_W-1:0]                h2;
  logic signed [ACC_W-1:0]                h3;
  logic signed [csi_pkg::T_W:0]           t_s;
  logic signed [csi_pkg::CNT_W+1:0]       rel;
  logic                                   wr_rate;
  logic                                   rate_ok;

  assign rdata    = st_r.rdata;
  assign sp       = st_r.sp;
  assign sp_valid = st_r.sp_valid;
  assign sp_axes  = st_r.run.axes;
  assign busy     = st_r.busy;

  assign wr_rate = wr && (addr == csi_pkg::A_RATE);
  assign rate_ok = (wdata[csi_pkg::RATE_W-1:0] >= csi_pkg::RATE_MIN)
                && (wdata[csi_pkg::RATE_W-1:0] <= csi_pkg::RATE_MAX)
                && (wdata[31:csi_pkg::RATE_W] == '0);

  // spline commands go through the queue
  always_comb begin
    q_in = '0;
    q_in_valid = 1'b0;
    if (wr_rate && rate_ok) begin
      q_in.op = csi_pkg::CSI_CMD_RATE;
      q_in.arg = 48'(wdata[csi_pkg::RATE_W-1:0]);
      q_in_valid = 1'b1;
    end else if (wr && addr == csi_pkg::A_SHIFT) begin
      q_in.op = csi_pkg::CSI_CMD_SCALE;
      q_in.arg = {5'h00, st_r.stg_axis, st_r.stg_mult, wdata[POS_W-1:0]};
      q_in_valid = 1'b1;
    end else if (wr && addr == csi_pkg::A_GO) begin
      q_in.op = csi_pkg::CSI_CMD_START;
      q_in.arg = {st_r.span_cnt, st_r.span_idx,
                  wdata[csi_pkg::REP_W-1:0],
                  wdata[csi_pkg::HI_LSB +: csi_pkg::NAX]};
      q_in_valid = 1'b1;
    end
  end

  // queue drains only while no run is active
  assign q_out_ready = (st_r.ph == csi_pkg::S_IDLE) && !st_r.busy;

  csi_fifo #(
    .W     (csi_pkg::CMD_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (csi_pkg::FIFO_CNT_W - 1)
  ) u_queue (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .in_data   (q_in),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready),
    .out_data  (q_out),
    .level     (q_level)
  );

  csi_div #(
    .W  (csi_pkg::T_W),
    .DW (csi_pkg::RATE_W)
  ) u_div (
    .clock (clock),
    .rst   (rst),
    .go    (st_r.div_go),
    .num   (st_r.k),
    .den   (st_r.rate),
    .quo   (div_q),
    .done  (div_done)
  );

  // neighbour index clamped to the span
  always_comb begin
    rel = signed'({2'b00, st_r.seg}) + signed'((csi_pkg::CNT_W+2)'(st_r.j))
        - signed'((csi_pkg::CNT_W+2)'(1));
    if (rel < 0) rel = '0;
    if (rel > signed'({2'b00, st_r.run.cnt}) - 1)
      rel = (csi_pkg::CNT_W+2)'(signed'({2'b00, st_r.run.cnt}) - 1);
    rd_addr = st_r.run.idx + rel[csi_pkg::IDX_W-1:0];
  end

  // table store: writes proceed at any time, reads one cycle late
  always_ff @(posedge clock) begin
    if (wr && addr == csi_pkg::A_TDATA) tbl[st_r.taddr] <= wdata[POS_W-1:0];
    tbl_q <= tbl[rd_addr];
  end

  // catmull-rom segment evaluated in fixed point
  assign p0  = ACC_W'(signed'(st_r.p[0]));
  assign p1  = ACC_W'(signed'(st_r.p[1]));
  assign p2  = ACC_W'(signed'(st_r.p[2]));
  assign p3  = ACC_W'(signed'(st_r.p[3]));
  assign t_s = signed'({1'b0, st_r.t});
  assign c_a = 3 * (p1 - p2) + p3 - p0;
  assign c_b = 2 * p0 - 5 * p1 + 4 * p2 - p3;
  assign c_c = p2 - p0;
  assign h1  = ((c_a * t_s) >>> csi_pkg::T_W) + c_b;
  assign h2  = ((h1 * t_s) >>> csi_pkg::T_W) + c_c;
  assign h3  = ((h2 * t_s) >>> (csi_pkg::T_W + 1)) + p1;

  // scale, shift and clip to the setpoint width
  function automatic logic [POS_W-1:0] scale_sat(
    input logic signed [ACC_W-1:0] v,
    input logic [csi_pkg::MULT_W-1:0] mult,
    input logic [POS_W-1:0] sh
  );
    logic signed [ACC_W-1:0] m;
    logic signed [ACC_W-1:0] s;
    logic signed [ACC_W-1:0] hi;
    logic signed [ACC_W-1:0] lo;
    hi = (ACC_W'(1) <<< (POS_W - 1)) - 1;
    lo = -(ACC_W'(1) <<< (POS_W - 1));
    m = (v * ACC_W'(signed'(mult))) >>> csi_pkg::MULT_FRAC;
    s = m + ACC_W'(signed'(sh));
    if (s > hi) s = hi;
    if (s < lo) s = lo;
    return s[POS_W-1:0];
  endfunction : scale_sat

  always_comb begin
    csi_pkg::csi_scale_s sc;
    csi_pkg::csi_start_s sr;
    sc = q_out.arg;
    sr = q_out.arg;
    st_nxt = st_r;
    st_nxt.sp_valid = 1'b0;
    st_nxt.div_go = 1'b0;
    st_nxt.rdata = '0;

    // staging, table and control writes never wait
    if (wr) begin
      unique case (addr)
        csi_pkg::A_CTRL: begin
          if (wdata[csi_pkg::CTRL_CLR]) begin
            st_nxt.ovf = 1'b0;
            st_nxt.badrate = 1'b0;
          end
        end
        csi_pkg::A_STAGE: begin
          st_nxt.stg_axis = wdata[csi_pkg::HI_LSB +: csi_pkg::AX_W];
          st_nxt.stg_mult = wdata[csi_pkg::MULT_W-1:0];
        end
        csi_pkg::A_SPAN: begin
          st_nxt.span_cnt = wdata[csi_pkg::HI_LSB +: csi_pkg::CNT_W];
          st_nxt.span_idx = wdata[csi_pkg::IDX_W-1:0];
        end
        csi_pkg::A_TADDR: st_nxt.taddr = wdata[csi_pkg::IDX_W-1:0];
        csi_pkg::A_TDATA: st_nxt.taddr = st_r.taddr + 1'b1;
        default: ;
      endcase
    end
    // error flags: a new event wins over a clear in the same cycle
    if (wr_rate && !rate_ok) st_nxt.badrate = 1'b1;
    if (q_in_valid && !q_in_ready) st_nxt.ovf = 1'b1;

    if (rd) begin
      unique case (addr)
        csi_pkg::A_CTRL: begin
          st_nxt.rdata[csi_pkg::ST_BUSY] = st_r.busy;
          st_nxt.rdata[csi_pkg::ST_FULL] = !q_in_ready;
          st_nxt.rdata[csi_pkg::ST_OVF] = st_r.ovf;
          st_nxt.rdata[csi_pkg::ST_BADRATE] = st_r.badrate;
          st_nxt.rdata[csi_pkg::ST_CNT_LSB +: csi_pkg::FIFO_CNT_W] = q_level;
        end
        csi_pkg::A_RATE: st_nxt.rdata = 32'(st_r.rate);
        csi_pkg::A_STAGE:
          st_nxt.rdata = {13'h0000, st_r.stg_axis, st_r.stg_mult};
        csi_pkg::A_SPAN:
          st_nxt.rdata = {3'h0, st_r.span_cnt, 4'h0, st_r.span_idx};
        csi_pkg::A_TADDR: st_nxt.rdata = 32'(st_r.taddr);
        default: st_nxt.rdata = '0;
      endcase
    end

    // held commands take effect one at a time once idle
    if (q_out_valid && q_out_ready) begin
      unique case (q_out.op)
        // code sets spacing, one step per code unit
        csi_pkg::CSI_CMD_RATE: st_nxt.rate = q_out.arg[csi_pkg::RATE_W-1:0];
        csi_pkg::CSI_CMD_SCALE: begin
          st_nxt.mult[sc.axis] = sc.mult;
          st_nxt.shift[sc.axis] = sc.shift;
        end
        csi_pkg::CSI_CMD_START: begin
          // span and axes latched for the run
          st_nxt.run = sr;
          st_nxt.seg = '0;
          st_nxt.k = '0;
          st_nxt.pass = '0;
          st_nxt.tick = '0;
          if (sr.cnt != '0) begin
            st_nxt.busy = 1'b1;
            st_nxt.j = '0;
            st_nxt.ph = csi_pkg::S_FETCH;
          end
        end
        default: ;
      endcase
    end

    // step timer, one pulse each 200 us
    if (st_r.busy) begin
      if (st_r.tick == csi_pkg::TICK_W'(csi_pkg::STEP_CYC - 1))
        st_nxt.tick = '0;
      else
        st_nxt.tick = st_r.tick + 1'b1;
    end

    unique case (st_r.ph)
      csi_pkg::S_IDLE: ;
      csi_pkg::S_WAIT: begin
        if (st_r.tick == csi_pkg::TICK_W'(csi_pkg::STEP_CYC - 1)) begin
          st_nxt.j = '0;
          st_nxt.ph = csi_pkg::S_FETCH;
        end
      end
      csi_pkg::S_FETCH: begin
        // four neighbours, each arriving one cycle after its address
        if (st_r.j != '0) st_nxt.p[st_r.j - 1'b1] = tbl_q;
        if (st_r.j == 3'h4) begin
          st_nxt.div_go = 1'b1;
          st_nxt.ph = csi_pkg::S_DIV;
        end else begin
          st_nxt.j = st_r.j + 1'b1;
        end
      end
      csi_pkg::S_DIV: begin
        if (div_done) begin
          st_nxt.t = div_q;
          st_nxt.ph = csi_pkg::S_EVAL;
        end
      end
      csi_pkg::S_EVAL: begin
        // each selected axis gets its own scaling
        for (int i = 0; i < csi_pkg::NAX; i++) begin
          if (st_r.run.axes[i])
            st_nxt.sp[i] = scale_sat(h3, st_r.mult[i], st_r.shift[i]);
        end
        st_nxt.sp_valid = 1'b1;
        st_nxt.ph = csi_pkg::S_WAIT;
        if (st_r.seg >= st_r.run.cnt - 1'b1) begin
          st_nxt.seg = '0;
          st_nxt.k = '0;
          // finite repeat ends, zero loops forever
          if (st_r.run.rep != '0 && st_r.pass + 1'b1 == st_r.run.rep) begin
            st_nxt.busy = 1'b0;
            st_nxt.ph = csi_pkg::S_IDLE;
          end else begin
            st_nxt.pass = st_r.pass + 1'b1;
          end
        end else if (st_r.k + 1'b1 == st_r.rate) begin
          st_nxt.k = '0;
          st_nxt.seg = st_r.seg + 1'b1;
        end else begin
          st_nxt.k = st_r.k + 1'b1;
        end
      end
      default: st_nxt.ph = csi_pkg::S_IDLE;
    endcase

    // stop last: a phase step must not revive a stopped run
    if (wr && addr == csi_pkg::A_CTRL && wdata[csi_pkg::CTRL_STOP]) begin
      st_nxt.busy = 1'b0;
      st_nxt.ph = csi_pkg::S_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
      st_r.ph <= csi_pkg::S_IDLE;
      st_r.rate <= csi_pkg::RATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : csi_core
`default_nettype wire

// [test/csi_core_properties.sv]
// port assertions for the spline interpolator core
`timescale 1ns/1ps
`default_nettype none
module csi_core_props (
  // clock and reset
  input wire logic                                   clock,
  input wire logic                                   rst,
  // register port
  input wire logic [7:0]                             addr,
  input wire logic [31:0]                            wdata,
  input wire logic                                   wr,
  input wire logic                                   rd,
  input wire logic [31:0]                            rdata,
  // setpoint stream
  input wire logic [csi_pkg::NAX-1:0][csi_pkg::POS_W-1:0] sp,
  input wire logic                                   sp_valid,
  input wire logic [csi_pkg::NAX-1:0]                sp_axes,
  input wire logic                                   busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [csi_pkg::NAX-1:0][csi_pkg::POS_W-1:0] umask;
  logic [15:0] gap_r;
  logic [15:0] gap_nxt;
  logic        seen_r;
  logic        seen_nxt;
  always_comb begin
    for (int i = 0; i < csi_pkg::NAX; i++) begin
      umask[i] = {csi_pkg::POS_W{~sp_axes[i]}};
    end
    gap_nxt = sp_valid ? 16'h0000 : gap_r + 16'h0001;
    // busy drops with the last point, so keep seen one cycle longer
    seen_nxt = sp_valid | (seen_r & busy);
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      gap_r  <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= gap_nxt;
      seen_r <= seen_nxt;
    end
  end
  rd_idle_a: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  rate_range_a: assert property (
    $past(rd && addr == csi_pkg::A_RATE) |->
      rdata >= 32'h0000_0005 && rdata <= 32'h0000_01ff)
    else $error("applied interval code out of range");
  step_gap_a: assert property (
    sp_valid && seen_r |-> gap_r == 16'(csi_pkg::STEP_CYC - 1))
    else $error("setpoint spacing is not one step");
  valid_pulse_a: assert property (sp_valid |=> !sp_valid)
    else $error("setpoint strobe longer than a cycle");
  first_point_a: assert property ($rose(busy) |-> ##[1:60] sp_valid)
    else $error("run gave no first setpoint");
  sp_hold_a: assert property (!sp_valid |-> $stable(sp))
    else $error("setpoint moved without strobe");
  axes_only_a: assert property (
    ((sp ^ $past(sp)) & umask) == '0)
    else $error("unselected axis setpoint changed");
  valid_busy_a: assert property (sp_valid |-> busy || $past(busy))
    else $error("setpoint outside a run");
  status_busy_a: assert property (
    $past(rd && addr == csi_pkg::A_CTRL) |->
      rdata[csi_pkg::ST_BUSY] == $past(busy))
    else $error("status busy bit wrong");
  cover property ($rose(busy));
  cover property ($fell(busy));
  cover property (sp_valid && sp_axes == 8'h03);
endmodule : csi_core_props
`default_nettype wire

// [test/csi_host_model.sv]
// host side model issuing register cycles and spline commands
`timescale 1ns/1ps
`default_nettype none
module csi_host_model (
  // clock
  input  wire logic        clock,
  // register port, host side
  output var  logic [7:0]  addr,
  output var  logic [31:0] wdata,
  output var  logic        wr,
  output var  logic        rd,
  input  wire logic [31:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    // released data must not look valid
    wdata <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  // q2.14 holds only -2 up to under 2
  task automatic run(input logic [8:0] rate, input logic [15:0] m0, m1,
                     input logic [23:0] s0, s1,
                     input logic [31:0] span, go);
    wr_reg(csi_pkg::A_RATE, {23'h0, rate});
    wr_reg(csi_pkg::A_STAGE, {16'h0000, m0});
    wr_reg(csi_pkg::A_SHIFT, {8'h00, s0});
    wr_reg(csi_pkg::A_STAGE, {16'h0001, m1});
    wr_reg(csi_pkg::A_SHIFT, {8'h00, s1});
    wr_reg(csi_pkg::A_SPAN, span);
    wr_reg(csi_pkg::A_GO, go);
  endtask : run
endmodule : csi_host_model
`default_nettype wire

// [test/csi_core_tb_top.sv]
// self-checking bench for the spline interpolator core
`timescale 1ns/1ps
`default_nettype none
module csi_core_tb_top;
  logic        clock;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [csi_pkg::NAX-1:0][csi_pkg::POS_W-1:0] sp;
  logic        sp_valid;
  logic [7:0]  sp_axes;
  logic        busy;
  int          fails;
  int          samples_checked;
  int          cycles;
  int          nvalid;
  csi_core #(.FIFO_DEPTH(32)) DUT (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sp(sp),
    .sp_valid(sp_valid), .sp_axes(sp_axes), .busy(busy));
  csi_host_model host (.clock(clock), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // cuts a hang short; the runs need about 32000 cycles
  always @(posedge clock) begin
    cycles++;
    if (sp_valid === 1'b1) nvalid++;
    if (cycles == 60000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wait_idle();
    int n = 0;
    repeat (3) @(posedge clock);
    while (busy !== 1'b0 && n < 40000) begin
      @(posedge clock);
      n++;
    end
    #1;
  endtask : wait_idle
  task automatic test_regs();
    logic [31:0] d;
    host.rd_reg(csi_pkg::A_RATE, d);
    check("rate reset", 32'h0000_0005, d);
    host.rd_reg(8'h20, d);
    check("unmapped read", 32'h0000_0000, d);
    host.wr_reg(csi_pkg::A_RATE, 32'h0000_0004);
    host.rd_reg(csi_pkg::A_CTRL, d);
    check("bad code flag", 32'h0000_0001, {31'h0, d[3]});
    host.wr_reg(csi_pkg::A_RATE, 32'h0000_0200);
    host.rd_reg(csi_pkg::A_RATE, d);
    check("rate kept", 32'h0000_0005, d);
    host.wr_reg(csi_pkg::A_RATE, 32'h0000_01ff);
    host.rd_reg(csi_pkg::A_RATE, d);
    check("rate top", 32'h0000_01ff, d);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_repeat();
    host.wr_reg(csi_pkg::A_TADDR, 32'h0000_000a);
    host.wr_reg(csi_pkg::A_TDATA, 32'h0000_0190);
    nvalid = 0;
    host.run(9'h005, 16'h2000, 16'hc000, 24'h00_0007, 24'h00_0000,
             32'h0001_000a, 32'h0003_0003);
    wait_idle();
    check("pass count", 32'h0000_0003, 32'(nvalid));
    check("axis0 point", 32'h0000_00cf, {8'h00, sp[0]});
    check("axis1 point", 32'h00ff_fe70, {8'h00, sp[1]});
    check("axis2 point", 32'h0000_0000, {8'h00, sp[2]});
    $display("test_repeat done");
  endtask : test_repeat
  task automatic test_hold();
    logic [31:0] d;
    host.wr_reg(csi_pkg::A_TADDR, 32'h0000_0014);
    host.wr_reg(csi_pkg::A_TDATA, 32'h0000_0064);
    host.wr_reg(csi_pkg::A_TDATA, 32'h0000_0384);
    nvalid = 0;
    host.run(9'h005, 16'h2000, 16'hc000, 24'h00_0007, 24'h00_0000,
             32'h0002_0014, 32'h0003_0001);
    // interval and scale sent mid-run must wait for the end
    host.wr_reg(csi_pkg::A_RATE, 32'h0000_0007);
    host.wr_reg(csi_pkg::A_STAGE, 32'h0000_4000);
    host.wr_reg(csi_pkg::A_SHIFT, 32'h0000_0000);
    host.rd_reg(csi_pkg::A_RATE, d);
    check("rate held", 32'h0000_0005, d);
    host.rd_reg(csi_pkg::A_STAGE, d);
    check("stage now", 32'h0000_4000, d);
    wait_idle();
    check("step count", 32'h0000_0006, 32'(nvalid));
    check("axis0 end", 32'h0000_01c9, {8'h00, sp[0]});
    check("axis1 end", 32'h00ff_fc7c, {8'h00, sp[1]});
    host.rd_reg(csi_pkg::A_RATE, d);
    check("rate after", 32'h0000_0007, d);
    $display("test_hold done");
  endtask : test_hold
  task automatic test_stop();
    logic [31:0] d;
    nvalid = 0;
    host.run(9'h005, 16'h4000, 16'h4000, 24'h00_0000, 24'h00_0000,
             32'h0001_000a, 32'h0001_0000);
    // one full pass, then stop while the next point is being divided
    repeat (4020) @(posedge clock);
    host.rd_reg(csi_pkg::A_CTRL, d);
    check("loop busy", 32'h0000_0001, {31'h0, d[0]});
    host.wr_reg(csi_pkg::A_CTRL, 32'h0000_0001);
    host.wr_reg(csi_pkg::A_RATE, 32'h0000_0009);
    host.rd_reg(csi_pkg::A_RATE, d);
    check("drain after stop", 32'h0000_0009, d);
    check("stop points", 32'h0000_0001, 32'(nvalid));
    check("stop axes", 32'h0000_0001, {24'h00_0000, sp_axes});
    check("loop point", 32'h0000_0190, {8'h00, sp[0]});
    $display("test_stop done");
  endtask : test_stop
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    rst = 1'b1;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    nvalid = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    test_regs();
    test_repeat();
    test_hold();
    test_stop();
    give_verdict();
  end
endmodule : csi_core_tb_top
bind csi_core csi_core_props u_props (.clock(clock), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sp(sp),
  .sp_valid(sp_valid), .sp_axes(sp_axes), .busy(busy));
`default_nettype wire
